// [ocwc_compositor.sv]
// Purpose: Per-dot color, transparency, position and windows
// Assumes: clk_i is the dot clock; sync refs are 1-cycle pulses
// Notes:   Registers over classic Wishbone, 16 bits in low lanes
// What this block does
// - Character blue/green/red from word bits A,9,8
// - Raster blue/green/red from word bits D,C,B
// - Char intensity from selected extended set
// - Raster intensity from selected extended set
// - Extended enabled: select picks stored attribute set
// - Extended disabled: bits give blink, shadow only
// - Font 1 dots char color, 0 raster
// - Multi-color font: OR three patterns first
// - Black raster transparent when transparency enabled
// - Shadow and character dots never transparent
// - Horizontal start delay is position times 6
// - Vertical top margin is position times 4
// - Window rows in font units, 0 to 14
// - Window columns in font units, 0 to 29
// - Per-window shadow width and height fields
// - Shadow size is twice field, dots/lines
// - Window shadow always drawn black
// - Shadow may extend past display area
// - Window starts at start cell's top-left
// - Window ends at stop cell's bottom-right
// - Enabled windows shown, ordered by rank register
// - Rank 0 highest, rank 3 lowest priority
// - Shadow drawn only with shade enable set
`timescale 1ns/1ps
`include "ocwc_regs.svh"

module ocwc_compositor
	import ocwc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Sync references
	input  wire logic        hsync_ref_i,
	input  wire logic        vsync_ref_i,
	// Current cell and dot data
	input  wire logic [15:0] cell_word_i,
	input  wire logic [2:0]  font_bits_i,
	input  wire logic        multi_color_i,
	input  wire logic        char_shadow_i,
	input  wire logic        blink_phase_i,
	// Dot position toward fetch logic
	output logic      [11:0] dot_x_o,
	output logic      [11:0] dot_y_o,
	output logic             dot_valid_o,
	// Video toward the amplifier
	output logic             red_o,
	output logic             green_o,
	output logic             blue_o,
	output logic             intensity_o,
	output logic             osd_drive_o
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	// Byte-lane write merge, reserved bits masked out
	function automatic ocwc_reg_t wr16(input ocwc_reg_t old,
		input logic [15:0] dat, input logic [1:0] sel,
		input ocwc_reg_t msk);
		ocwc_reg_t bm;
		bm = {{8{sel[1]}}, {8{sel[0]}}} & msk;
		return (old & ~bm) | (dat & bm);
	endfunction : wr16

	// Rectangle of cells, shifted by an offset in dots/lines
	function automatic logic in_rect(input ocwc_coord_t x,
		input ocwc_coord_t y, input logic [3:0] rs,
		input logic [3:0] re, input logic [4:0] cs,
		input logic [4:0] ce, input ocwc_coord_t ox,
		input ocwc_coord_t oy);
		ocwc_coord_t x0;
		ocwc_coord_t x1;
		ocwc_coord_t y0;
		ocwc_coord_t y1;
		x0 = 12'(12'(cs) * `OCWC_CELL_W) + ox;
		x1 = 12'(12'(5'(ce + 5'h01)) * `OCWC_CELL_W) + ox;
		y0 = 12'(12'(rs) * `OCWC_CELL_H) + oy;
		y1 = 12'(12'(5'(re) + 5'h01) * `OCWC_CELL_H) + oy;
		return (x >= x0) && (x < x1) && (y >= y0) && (y < y1);
	endfunction : in_rect

	// ---------------------------------------------------------------
	// Register file state
	// ---------------------------------------------------------------
	ocwc_reg_t   ctl0_ff;
	ocwc_reg_t   pos_ff;
	ocwc_reg_t   ext_ff;
	ocwc_reg_t   rank_ff;
	ocwc_reg_t   wrow_ff     [4];
	ocwc_reg_t   wcol_ff     [4];
	logic        ack_ff;
	logic [31:0] rdat_ff;
	ocwc_reg_t   nxt_ctl0;
	ocwc_reg_t   nxt_pos;
	ocwc_reg_t   nxt_ext;
	ocwc_reg_t   nxt_rank;
	ocwc_reg_t   nxt_wrow    [4];
	ocwc_reg_t   nxt_wcol    [4];
	logic        nxt_ack;
	logic [31:0] nxt_rdat;
	logic        hit;
	logic        wr;
	logic [1:0]  wsel;

	// Timing state
	ocwc_coord_t h_ff;
	ocwc_coord_t v_ff;
	ocwc_coord_t x_ff;
	ocwc_coord_t y_ff;
	logic        xv_ff;
	logic        yv_ff;
	logic        valid_ff;
	ocwc_coord_t nxt_h;
	ocwc_coord_t nxt_v;
	ocwc_coord_t nxt_x;
	ocwc_coord_t nxt_y;
	logic        nxt_xv;
	logic        nxt_yv;
	ocwc_coord_t hoff;
	ocwc_coord_t voff;

	// Output state
	logic        red_ff;
	logic        green_ff;
	logic        blue_ff;
	logic        int_ff;
	logic        drv_ff;
	logic        nxt_red;
	logic        nxt_green;
	logic        nxt_blue;
	logic        nxt_int;
	logic        nxt_drv;

	// ---------------------------------------------------------------
	// Wishbone slave
	// ---------------------------------------------------------------
	// Ack one cycle after the strobe, dropped the cycle after
	assign hit  = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr   = hit & wb_we_i;
	assign wsel = wb_sel_i[1:0];

	// Next register values and read data
	always_comb begin
		nxt_ack  = hit;
		nxt_ctl0 = ctl0_ff;
		nxt_pos  = pos_ff;
		nxt_ext  = ext_ff;
		nxt_rank = rank_ff;
		nxt_rdat = rdat_ff;
		for (int w = 0; w < 4; w++) begin
			nxt_wrow[w] = wrow_ff[w];
			nxt_wcol[w] = wcol_ff[w];
		end
		if (wr) begin
			case (wb_adr_i & 8'hFC)
				`OCWC_OFF_CTL0: nxt_ctl0 = wr16(ctl0_ff, wb_dat_i[15:0], wsel, `OCWC_MSK_CTL0);
				`OCWC_OFF_POS:  nxt_pos  = wr16(pos_ff, wb_dat_i[15:0], wsel, `OCWC_MSK_POS);
				`OCWC_OFF_EXT:  nxt_ext  = wr16(ext_ff, wb_dat_i[15:0], wsel, `OCWC_MSK_EXT);
				`OCWC_OFF_RANK: nxt_rank = wr16(rank_ff, wb_dat_i[15:0], wsel, `OCWC_MSK_RANK);
				default: begin
				end
			endcase
			for (int w = 0; w < 4; w++) begin
				if ((wb_adr_i & 8'hFC) == 8'(`OCWC_OFF_WROW0 + 8'(w * 4)))
					nxt_wrow[w] = wr16(wrow_ff[w], wb_dat_i[15:0], wsel, `OCWC_MSK_WROW);
				if ((wb_adr_i & 8'hFC) == 8'(`OCWC_OFF_WCOL0 + 8'(w * 4)))
					nxt_wcol[w] = wr16(wcol_ff[w], wb_dat_i[15:0], wsel, `OCWC_MSK_WCOL);
			end
		end
		// Unmapped offsets read zero and are still acked
		if (hit) begin
			nxt_rdat = 32'h0000_0000;
			case (wb_adr_i & 8'hFC)
				`OCWC_OFF_CTL0: nxt_rdat[15:0] = ctl0_ff;
				`OCWC_OFF_POS:  nxt_rdat[15:0] = pos_ff;
				`OCWC_OFF_EXT:  nxt_rdat[15:0] = ext_ff;
				`OCWC_OFF_RANK: nxt_rdat[15:0] = rank_ff;
				`OCWC_OFF_STAT: nxt_rdat = {4'h0, v_ff, 13'h0000, drv_ff, yv_ff, xv_ff};
				default: begin
				end
			endcase
			for (int w = 0; w < 4; w++) begin
				if ((wb_adr_i & 8'hFC) == 8'(`OCWC_OFF_WROW0 + 8'(w * 4)))
					nxt_rdat[15:0] = wrow_ff[w];
				if ((wb_adr_i & 8'hFC) == 8'(`OCWC_OFF_WCOL0 + 8'(w * 4)))
					nxt_rdat[15:0] = wcol_ff[w];
			end
		end
	end

	// Register file flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0000_0000;
			ctl0_ff <= `OCWC_RST_REG;
			pos_ff  <= `OCWC_RST_REG;
			ext_ff  <= `OCWC_RST_REG;
			rank_ff <= `OCWC_RST_RANK;
			for (int w = 0; w < 4; w++) begin
				wrow_ff[w] <= `OCWC_RST_REG;
				wcol_ff[w] <= `OCWC_RST_REG;
			end
		end else begin
			ack_ff  <= nxt_ack;
			rdat_ff <= nxt_rdat;
			ctl0_ff <= nxt_ctl0;
			pos_ff  <= nxt_pos;
			ext_ff  <= nxt_ext;
			rank_ff <= nxt_rank;
			for (int w = 0; w < 4; w++) begin
				wrow_ff[w] <= nxt_wrow[w];
				wcol_ff[w] <= nxt_wcol[w];
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// ---------------------------------------------------------------
	// Dot and line counters
	// ---------------------------------------------------------------
	// Display origin relative to the sync reference edges
	assign hoff = 12'(12'(pos_ff[15:8]) * `OCWC_HP_STEP);
	assign voff = 12'(12'(pos_ff[7:0]) * `OCWC_VP_STEP);

	// Counters saturate so a missing sync cannot wrap into view
	always_comb begin
		nxt_h = (h_ff == `OCWC_CNT_MAX) ? h_ff : h_ff + 12'h001;
		nxt_v = v_ff;
		if (hsync_ref_i) begin
			nxt_h = 12'h000;
			nxt_v = (v_ff == `OCWC_CNT_MAX) ? v_ff : v_ff + 12'h001;
		end
		if (vsync_ref_i)
			nxt_v = 12'h000;
		nxt_xv = h_ff >= hoff;
		nxt_yv = v_ff >= voff;
		nxt_x  = nxt_xv ? h_ff - hoff : 12'h000;
		nxt_y  = nxt_yv ? v_ff - voff : 12'h000;
	end

	// Counter flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			h_ff  <= 12'h000;
			v_ff  <= 12'h000;
			x_ff  <= 12'h000;
			y_ff  <= 12'h000;
			xv_ff <= 1'b0;
			yv_ff <= 1'b0;
			valid_ff <= 1'b0;
		end else begin
			h_ff  <= nxt_h;
			v_ff  <= nxt_v;
			x_ff  <= nxt_x;
			y_ff  <= nxt_y;
			xv_ff <= nxt_xv;
			yv_ff <= nxt_yv;
			valid_ff <= nxt_xv & nxt_yv;
		end
	end

	assign dot_x_o     = x_ff;
	assign dot_y_o     = y_ff;
	assign dot_valid_o = valid_ff;

	// ---------------------------------------------------------------
	// Window and shadow hit per window
	// ---------------------------------------------------------------
	logic [3:0] win_hit;
	logic [3:0] sha_hit;
	// Area limits 0..14 rows, 0..29 columns are kept by software
	for (genvar w = 0; w < 4; w++) begin : g_win
		ocwc_coord_t sx;
		ocwc_coord_t sy;
		logic        ena;
		logic        in_win;
		logic        in_sha;
		assign ena = wrow_ff[w][`OCWC_WROW_EN];
		assign sx  = 12'({wrow_ff[w][13:12], 1'b0});
		assign sy  = 12'({wrow_ff[w][5:4], 1'b0});
		assign in_win = in_rect(x_ff, y_ff, wrow_ff[w][11:8], wrow_ff[w][3:0],
			wcol_ff[w][12:8], wcol_ff[w][4:0], 12'h000, 12'h000);
		// Shifted copy of the window, not clipped to the area
		assign in_sha = in_rect(x_ff, y_ff, wrow_ff[w][11:8], wrow_ff[w][3:0],
			wcol_ff[w][12:8], wcol_ff[w][4:0], sx, sy);
		assign win_hit[w] = ena & in_win;
		assign sha_hit[w] = ena & ~in_win & in_sha & wcol_ff[w][`OCWC_WCOL_SHA];
	end

	// ---------------------------------------------------------------
	// Dot composition
	// ---------------------------------------------------------------
	logic      font;
	logic [3:0] aset;
	logic      ext_en;
	logic      blink_a;
	logic      shade_a;
	logic      chr;
	logic      cshadow;
	ocwc_rgb_t rcol;
	ocwc_rgb_t ccol;
	logic      top_win;
	logic      top_sha;
	logic [1:0] wid;
	// Font dot, attributes and colors of the current cell
	always_comb begin
		ext_en  = ctl0_ff[`OCWC_CTL0_EXT];
		font    = multi_color_i ? |font_bits_i : font_bits_i[0];
		aset    = ext_ff[{cell_word_i[15:14], 2'b00} +: 4];
		blink_a = ext_en ? aset[3] : cell_word_i[15];
		shade_a = ext_en ? aset[2] : cell_word_i[14];
		ccol    = {cell_word_i[8], cell_word_i[9], cell_word_i[10]};
		rcol    = {cell_word_i[11], cell_word_i[12], cell_word_i[13]};
		chr     = font & ~(blink_a & blink_phase_i);
		cshadow = shade_a & ~chr & char_shadow_i;
	end

	// Highest priority hit; rank 3 walked first, rank 0 last
	always_comb begin
		top_win = 1'b0;
		top_sha = 1'b0;
		for (int k = 3; k >= 0; k--) begin
			wid = rank_ff[4 * k +: 2];
			if (win_hit[wid] | sha_hit[wid]) begin
				top_win = win_hit[wid];
				top_sha = sha_hit[wid];
			end
		end
	end

	// Color selection per dot
	always_comb begin
		nxt_red   = 1'b0;
		nxt_green = 1'b0;
		nxt_blue  = 1'b0;
		nxt_int   = 1'b0;
		nxt_drv   = 1'b0;
		if (xv_ff & yv_ff) begin
			if (top_sha) begin
				nxt_drv = 1'b1;
			end else if (top_win) begin
				if (chr) begin
					{nxt_red, nxt_green, nxt_blue} = ccol;
					nxt_int = ext_en & aset[0];
					nxt_drv = 1'b1;
				end else if (cshadow) begin
					nxt_drv = 1'b1;
				end else begin
					{nxt_red, nxt_green, nxt_blue} = rcol;
					nxt_int = ext_en & aset[1];
					// Black raster lets main video through
					nxt_drv = ~(ctl0_ff[`OCWC_CTL0_BLK] && rcol == 3'h0);
					if (!nxt_drv)
						nxt_int = 1'b0;
				end
			end
		end
	end

	// Output flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			red_ff   <= 1'b0;
			green_ff <= 1'b0;
			blue_ff  <= 1'b0;
			int_ff   <= 1'b0;
			drv_ff   <= 1'b0;
		end else begin
			red_ff   <= nxt_red;
			green_ff <= nxt_green;
			blue_ff  <= nxt_blue;
			int_ff   <= nxt_int;
			drv_ff   <= nxt_drv;
		end
	end

	assign red_o       = red_ff;
	assign green_o     = green_ff;
	assign blue_o      = blue_ff;
	assign intensity_o = int_ff;
	assign osd_drive_o = drv_ff;

endmodule : ocwc_compositor

// [ocwc_compositor_properties.sv]
// Purpose: Port-level properties of ocwc_compositor
// Assumes: One clock, one-cycle sync pulses
// Notes:   Bound to the design after endmodule
`timescale 1ns/1ps
module ocwc_compositor_properties (
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	// Sync and video
	input wire logic        hsync_ref_i,
	input wire logic        vsync_ref_i,
	input wire logic [11:0] dot_x_o,
	input wire logic [11:0] dot_y_o,
	input wire logic        dot_valid_o,
	input wire logic        red_o,
	input wire logic        green_o,
	input wire logic        blue_o,
	input wire logic        intensity_o,
	input wire logic        osd_drive_o
);
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// No sync and no bus: position counter runs undisturbed
	sequence quiet_s;
		!hsync_ref_i && !vsync_ref_i && !wb_cyc_i;
	endsequence
	ack_after_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	dark_undriven_a: assert property (!osd_drive_o |-> !(red_o || green_o || blue_o || intensity_o))
		else $error("color while not driving");
	drive_in_area_a: assert property (osd_drive_o |-> $past(dot_valid_o))
		else $error("drive outside display area");
	hsync_origin_a: assert property (hsync_ref_i |-> ##[2:3] dot_x_o == 12'h000)
		else $error("line start not at origin");
	dot_step_a: assert property (quiet_s ##1 quiet_s ##0 (dot_valid_o && dot_x_o < 12'hFFE)
		|=> dot_x_o == $past(dot_x_o) + 12'h001)
		else $error("dot position did not step");
	vsync_top_a: assert property (vsync_ref_i && !hsync_ref_i |-> ##[2:3] dot_y_o == 12'h000)
		else $error("frame start not at top");
endmodule : ocwc_compositor_properties
bind ocwc_compositor ocwc_compositor_properties u_props (.*);

// [ocwc_pkg.sv]
// Purpose: Shared types of the OSD color and window compositor
// Assumes: Constants live in ocwc_regs.svh
// Notes:   Types only
package ocwc_pkg;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef logic [11:0] ocwc_coord_t;
	typedef logic [15:0] ocwc_reg_t;
	typedef logic [2:0]  ocwc_rgb_t;

endpackage : ocwc_pkg

// [ocwc_regs.svh]
// Purpose: Offsets, field positions, reset values and counts
// Assumes: Byte-addressed Wishbone map, 16-bit registers
// Notes:   Definitions only
`ifndef OCWC_REGS_SVH
`define OCWC_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OCWC_OFF_CTL0   8'h00
`define OCWC_OFF_POS    8'h04
`define OCWC_OFF_EXT    8'h08
`define OCWC_OFF_RANK   8'h0C
`define OCWC_OFF_WROW0  8'h10
`define OCWC_OFF_WCOL0  8'h20
`define OCWC_OFF_STAT   8'h30

// ---------------------------------------------------------------
// Write masks (reserved bits stay zero) and reset values
// ---------------------------------------------------------------
`define OCWC_MSK_CTL0   16'h0003
`define OCWC_MSK_POS    16'hFFFF
`define OCWC_MSK_EXT    16'hFFFF
`define OCWC_MSK_RANK   16'h3333
`define OCWC_MSK_WROW   16'hBF3F
`define OCWC_MSK_WCOL   16'h1F9F
`define OCWC_RST_REG    16'h0000
`define OCWC_RST_RANK   16'h3210

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define OCWC_CTL0_EXT   0
`define OCWC_CTL0_BLK   1
`define OCWC_WROW_EN    15
`define OCWC_WCOL_SHA   7

// ---------------------------------------------------------------
// Geometry and timing counts
// ---------------------------------------------------------------
`define OCWC_CELL_W     12'h00C
`define OCWC_CELL_H     12'h012
`define OCWC_AREA_W     12'h168
`define OCWC_AREA_H     12'h10E
`define OCWC_HP_STEP    12'h006
`define OCWC_VP_STEP    12'h004
`define OCWC_CNT_MAX    12'hFFF

`endif

// [ocwc_video_amp.sv]
// Purpose: Video amplifier model mixing OSD with main video
// Assumes: OSD color valid while its drive flag is high
// Notes:   Registered mix, one cycle late
`timescale 1ns/1ps
module ocwc_video_amp (
	// Clock
	input wire logic       clk_i,
	// OSD and main video
	input wire logic [3:0] osd_rgbi_i,
	input wire logic       osd_drive_i,
	input wire logic [2:0] main_rgb_i,
	// Mixed video
	output logic     [3:0] mix_o
);
	// Main video passes wherever the OSD stays off
	always_ff @(posedge clk_i) begin
		mix_o <= osd_drive_i ? osd_rgbi_i : {1'b0, main_rgb_i};
	end
endmodule : ocwc_video_amp

// [tb_top.sv]
// Purpose: Self-checking bench for ocwc_compositor
// Assumes: Registers over classic Wishbone
// Notes:   Dot model mirrors two fixed windows
`timescale 1ns/1ps
`include "ocwc_regs.svh"
module tb_top;
	import ocwc_pkg::*;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hsync_ref_i, vsync_ref_i;
	logic multi_color_i, char_shadow_i, blink_phase_i, dot_valid_o, osd_drive_o;
	logic red_o, green_o, blue_o, intensity_o, mon, ext_en, tr_en, prio1;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, mix, expm;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [15:0] cell_word_i, q;
	logic [15:0] words [8] = '{16'h0700, 16'h6A00, 16'h8100, 16'hDC00, 16'hB300, 16'hC700, 16'h3800, 16'h8500};
	logic [2:0]  font_bits_i;
	logic [11:0] dot_x_o, dot_y_o, pat;
	logic [4:0]  expv;
	int          err_total, total_checks, first_line, first_dot, l0, d0;
	ocwc_compositor DUT (.*);
	ocwc_video_amp u_amp (.clk_i(clk_i), .osd_rgbi_i({intensity_o, red_o, green_o, blue_o}),
		.osd_drive_i(osd_drive_o), .main_rgb_i(pat[8:6]), .mix_o(mix));
	// ----------------
	// Clock and cell stimulus
	// ----------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// Pattern counter sweeps fonts, flags and cell words
	always @(posedge clk_i) begin
		pat <= pat + 12'h001;
		font_bits_i <= pat[2:0];
		multi_color_i <= pat[3];
		char_shadow_i <= pat[4];
		blink_phase_i <= pat[5];
		cell_word_i <= words[pat[9:7]];
	end
	// ----------------
	// Checks
	// ----------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	// Expected {drive, red, green, blue, intensity} of one dot
	function automatic logic [4:0] model(input logic [11:0] x, input logic [11:0] y, input logic v,
		input logic [15:0] w, input logic [2:0] f, input logic m, input logic s, input logic b);
		logic [3:0] st;
		logic       iw0, iw1, ish, ch;
		st = ext_en ? 4'(16'h8421 >> {w[15:14], 2'b00}) : {w[15], w[14], 2'b00};
		iw0 = v && x < 12'h018 && y < 12'h012;
		iw1 = v && x >= 12'h00C && x < 12'h024 && y < 12'h012;
		ish = v && x >= 12'h002 && x < 12'h01A && y >= 12'h002 && y < 12'h014 && !iw0;
		ch = (m ? |f : f[0]) && !(st[3] && b);
		if (!(iw0 || iw1 || ish)) return 5'h00;
		if (ish && !(iw1 && prio1)) return 5'h10;
		if (ch) return {1'b1, w[8], w[9], w[10], st[0]};
		if (s && st[2]) return 5'h10;
		if (tr_en && w[13:11] == 3'h0) return 5'h00;
		return {1'b1, w[11], w[12], w[13], st[1]};
	endfunction : model
	// Outputs now belong to the dot seen one edge earlier
	always @(posedge clk_i) begin
		if (mon) chk("video", {27'h0, expv}, {27'h0, osd_drive_o, red_o, green_o, blue_o, intensity_o});
		if (mon) chk("mix", {28'h0, expm}, {28'h0, mix});
		// Amplifier registers the dot that was compared just now
		expm = expv[4] ? {expv[0], expv[3:1]} : {1'b0, pat[8:6]};
		expv = model(dot_x_o, dot_y_o, dot_valid_o, cell_word_i, font_bits_i, multi_color_i,
			char_shadow_i, blink_phase_i);
	end
	// ----------------
	// Bus and frame tasks
	// ----------------
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_sel_i <= 4'h3;
		wb_adr_i <= a;
		wb_dat_i <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
		if (n >= 20) begin
			err_total++;
			tally_and_finish;
		end
	endtask : wb
	// One frame of 32 lines, 64 dots each
	task automatic frame(input logic m);
		first_line = -1;
		vsync_ref_i <= 1'b1;
		mon <= m;
		@(posedge clk_i);
		vsync_ref_i <= 1'b0;
		for (int ln = 0; ln < 32; ln++) begin
			hsync_ref_i <= 1'b1;
			@(posedge clk_i);
			hsync_ref_i <= 1'b0;
			for (int c = 1; c < 64; c++) begin
				@(posedge clk_i);
				if (dot_valid_o === 1'b1 && first_line < 0) begin
					first_line = ln;
					first_dot = c;
				end
			end
		end
		mon <= 1'b0;
	endtask : frame
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, hsync_ref_i, vsync_ref_i, mon, ext_en, tr_en, prio1} = 10'h200;
		{wb_adr_i, wb_dat_i, wb_sel_i, pat} = '0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, `OCWC_OFF_RANK, 16'h0000);
		chk("rank reset", 32'h3210, {16'h0, q});
		wb(1'b1, 8'h3C, 16'hFFFF);
		wb(1'b0, 8'h3C, 16'h0000);
		chk("unmapped", 32'h0, {16'h0, q});
		wb(1'b1, `OCWC_OFF_WROW0, 16'h9010);
		wb(1'b1, `OCWC_OFF_WCOL0, 16'h0081);
		wb(1'b1, 8'h14, 16'h8000);
		wb(1'b1, 8'h24, 16'h0102);
		wb(1'b1, `OCWC_OFF_EXT, 16'h8421);
		wb(1'b0, `OCWC_OFF_WCOL0, 16'h0000);
		chk("window col", 32'h0081, {16'h0, q});
		// Nonzero baseline: a zero origin is valid before the first line
		wb(1'b1, `OCWC_OFF_POS, 16'h0101);
		frame(1'b0);
		l0 = first_line;
		d0 = first_dot;
		wb(1'b1, `OCWC_OFF_POS, 16'h0303);
		frame(1'b0);
		chk("h offset", 32'(d0 + 12), 32'(first_dot));
		chk("v offset", 32'(l0 + 8), 32'(first_line));
		wb(1'b1, `OCWC_OFF_POS, 16'h0000);
		// Every transparency and extended-set mode, ranks swapped in the last one
		for (int k = 0; k < 4; k++) begin
			// Model flags first, so no edge sees them change with the monitor
			ext_en = k[0];
			tr_en = k[1];
			prio1 = (k == 3);
			wb(1'b1, `OCWC_OFF_CTL0, 16'(k));
			if (k == 3) wb(1'b1, `OCWC_OFF_RANK, 16'h3201);
			frame(1'b1);
		end
		tally_and_finish;
	end
endmodule : tb_top
